/* core/usc_defines.vh */
`ifndef USC_DEFINES_VH
`define USC_DEFINES_VH
// ************
// register byte offsets
// ************
`define USC_OFS_CTRL1      8'h00
`define USC_OFS_CTRL2      8'h04
`define USC_OFS_SWCTRL     8'h08
`define USC_OFS_DATA       8'h0c
`define USC_OFS_BAUD       8'h10
`define USC_OFS_STATUS     8'h14
// ************
// control one fields
// ************
`define USC_C1_PORT_EN     7
`define USC_C1_WORD9       6
`define USC_C1_BREAK       2
`define USC_C1_RX9         1
`define USC_C1_TX9         0
// ************
// control two fields
// ************
`define USC_C2_TX_EN       7
`define USC_C2_RX_EN       6
`define USC_C2_SPEED       5
`define USC_C2_ADDR_EN     4
`define USC_C2_WAKE_EN     3
`define USC_C2_RX_IE       2
`define USC_C2_TXIDL_IE    1
`define USC_C2_TEMPTY_IE   0
// ************
// status fields
// ************
`define USC_ST_WAKE        5
`define USC_ST_OVERRUN     4
`define USC_ST_RX_IDLE     3
`define USC_ST_RX_AVAIL    2
`define USC_ST_TX_IDLE     1
`define USC_ST_TX_EMPTY    0
// ************
// reset values and timing
// ************
`define USC_CTRL_RST       8'h00
`define USC_OVERSAMPLE     4'hf
`define USC_MID_SAMPLE     4'h7
`define USC_LOW_PRESCALE   2'h3
`define USC_BREAK_BITS     4'hd
`define USC_RESP_OKAY      2'h0
`define USC_RESP_SLVERR    2'h2
`endif

/* core/usc_pin_sync.v */
`timescale 1ns/1ps
`default_nettype none
module usc_pin_sync (
   input  wire clk_i,
   input  wire rst_i,
   input  wire pin_i,
   output reg  level_o
);
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;
   // idle line is high; change accepted once stages two and three agree
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s1_reg  <= 1'b1;
         s2_reg  <= 1'b1;
         s3_reg  <= 1'b1;
         level_o <= 1'b1;
      end else begin
         s1_reg <= pin_i;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            level_o <= s3_reg;
         end
      end
   end
endmodule // usc_pin_sync
`default_nettype wire

/* core/usc_baud_gen.v */
`timescale 1ns/1ps
`default_nettype none
`include "usc_defines.vh"
module usc_baud_gen #(
   parameter DIV_W = 8
) (
   input  wire             clk_i,
   input  wire             rst_i,
   input  wire             run_i,
   input  wire             speed_hi_i,
   input  wire [DIV_W-1:0] divisor_i,
   output reg              tick_o
);
   reg [DIV_W-1:0] cnt_reg;
   reg [1:0]       pre_reg;
   // tick_o is one sixteenth of a bit; low speed adds a divide by four
   always @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_reg <= {DIV_W{1'b0}};
         pre_reg <= 2'h0;
         tick_o  <= 1'b0;
      end else if (!run_i) begin
         cnt_reg <= {DIV_W{1'b0}};
         pre_reg <= 2'h0;
         tick_o  <= 1'b0;
      end else if (cnt_reg >= divisor_i) begin
         cnt_reg <= {DIV_W{1'b0}};
         pre_reg <= pre_reg + 2'h1;
         tick_o  <= speed_hi_i | (pre_reg == `USC_LOW_PRESCALE);
      end else begin
         cnt_reg <= cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
         tick_o  <= 1'b0;
      end
   end
endmodule // usc_baud_gen
`default_nettype wire

/* core/usc_top.v */
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "usc_defines.vh"
// Function
// - transmitter disable aborts, clears, floats pin
// - transmit pin driven only when port and transmitter enabled
// - receiver disable aborts, clears; single wire transmitter then drives pin
// - receiver owns shared pin when both enabled
// - baud is clock over 64 or 16 times N+1
// - free-running eight bit divisor timer
// - address bit one marks address word, interrupts
// - address bit zero words discarded silently
// - falling shared pin wakes while clock stopped
// - no wake while clock runs or disabled
// - receive enable gates overrun and available flags
// - idle enable gates transmitter idle flag
// - empty enable gates transmit empty flag
// - no single wire: separate transmit pin
// - single wire: pin direction by enables
// - one shared eight bit data register
// - single wire upper bits zero; control resets zero
// - port disable empties, resets flags and counter; wake flag is kept
// - nine bit words use dedicated ninth bits
// - least significant bit first, shared format
// - idle flag when empty and nothing sending
module usc_top (
   input  wire        CORE_CLK_I,
   input  wire        SYS_RST_I,
   input  wire        PERIPH_CLK_OFF_I,
   input  wire [7:0]  S_AXI_AWADDR_I,
   input  wire        S_AXI_AWVALID_I,
   output reg         S_AXI_AWREADY_O,
   input  wire [31:0] S_AXI_WDATA_I,
   input  wire [3:0]  S_AXI_WSTRB_I,
   input  wire        S_AXI_WVALID_I,
   output reg         S_AXI_WREADY_O,
   output reg  [1:0]  S_AXI_BRESP_O,
   output reg         S_AXI_BVALID_O,
   input  wire        S_AXI_BREADY_I,
   input  wire [7:0]  S_AXI_ARADDR_I,
   input  wire        S_AXI_ARVALID_I,
   output reg         S_AXI_ARREADY_O,
   output reg  [31:0] S_AXI_RDATA_O,
   output reg  [1:0]  S_AXI_RRESP_O,
   output reg         S_AXI_RVALID_O,
   input  wire        S_AXI_RREADY_I,
   input  wire        RXTX_I,
   output reg         RXTX_O,
   output reg         RXTX_OE_O,
   output reg         TX_O,
   output reg         TX_OE_O,
   output reg         IRQ_O
);
   localparam ST_IDLE  = 3'h0;
   localparam ST_START = 3'h1;
   localparam ST_DATA  = 3'h2;
   localparam ST_STOP  = 3'h3;
   localparam ST_BRK   = 3'h4;

   function mapped;
      input [7:0] a;
      begin
         mapped = (a == `USC_OFS_CTRL1) || (a == `USC_OFS_CTRL2) || (a == `USC_OFS_SWCTRL) ||
                  (a == `USC_OFS_DATA) || (a == `USC_OFS_BAUD) || (a == `USC_OFS_STATUS);
      end
   endfunction

   // ************
   // registers and flags
   // ************
   reg [7:0]  ctrl1_reg;
   reg [7:0]  ctrl2_reg;
   reg        swmode_reg;
   reg [7:0]  data_buf_reg;
   reg [7:0]  baud_reg;
   reg        ovfl_reg;
   reg        rxav_reg;
   reg        txmt_reg;
   reg        txidl_reg;
   reg        wake_reg;
   reg        tx_pend_reg;
   reg        stat_seen_reg;
   reg [7:0]  aw_addr_reg;
   reg        aw_got_reg;
   reg [31:0] w_data_reg;
   reg        w_strb_reg;
   reg        w_got_reg;
   reg        rx_prev_reg;
   reg [2:0]  tx_state_reg;
   reg [3:0]  tx_os_reg;
   reg [3:0]  tx_idx_reg;
   reg [8:0]  tsr_reg;
   reg        tx_line_reg;
   reg [2:0]  rx_state_reg;
   reg [3:0]  rx_os_reg;
   reg [3:0]  rx_idx_reg;
   reg [8:0]  rsr_reg;
   reg        rx_done_reg;
   reg [7:0]  rdata_next;

   wire       port_en   = ctrl1_reg[`USC_C1_PORT_EN];
   wire       word9     = ctrl1_reg[`USC_C1_WORD9];
   wire       tx_en     = port_en & ctrl2_reg[`USC_C2_TX_EN];
   wire       rx_en     = port_en & ctrl2_reg[`USC_C2_RX_EN];
   wire       clk_run   = ~PERIPH_CLK_OFF_I;
   wire [3:0] last_bit  = word9 ? 4'h8 : 4'h7;
   wire       tick;
   wire       rx_pin;
   wire       wr_fire   = aw_got_reg & w_got_reg & ~S_AXI_BVALID_O;
   wire       rd_fire   = S_AXI_ARVALID_I & S_AXI_ARREADY_O;
   wire       wr_data   = wr_fire & w_strb_reg & (aw_addr_reg == `USC_OFS_DATA);
   wire       rd_data   = rd_fire & (S_AXI_ARADDR_I == `USC_OFS_DATA);
   wire       tx_load   = tx_en & clk_run & tx_pend_reg & (tx_state_reg == ST_IDLE);
   // single wire with both enables keeps the pin as input only
   wire       sw_tx     = swmode_reg & tx_en & ~rx_en;
   // receiver sees idle-high when it does not own the line
   wire       rx_line   = rx_en ? rx_pin : 1'b1;
   wire [8:0] rx_word   = word9 ? rsr_reg : {1'b0, rsr_reg[8:1]};
   wire       addr_bit  = word9 ? rx_word[8] : rx_word[7];
   wire       tx_busy   = (tx_state_reg != ST_IDLE);
   wire [7:0] status     = {2'h0, wake_reg, ovfl_reg, (rx_state_reg == ST_IDLE), rxav_reg,
                            txidl_reg, txmt_reg};

   usc_pin_sync u_rx_sync (
      .clk_i   (CORE_CLK_I),
      .rst_i   (SYS_RST_I),
      .pin_i   (RXTX_I),
      .level_o (rx_pin)
   );

   // counter held in reset while the port is off
   usc_baud_gen #(.DIV_W(8)) u_baud (
      .clk_i      (CORE_CLK_I),
      .rst_i      (SYS_RST_I),
      .run_i      (port_en & clk_run),
      .speed_hi_i (ctrl2_reg[`USC_C2_SPEED]),
      .divisor_i  (baud_reg),
      .tick_o     (tick)
   );

   // ************
   // bus handshake
   // ************
   always @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         S_AXI_AWREADY_O <= 1'b0;
         S_AXI_WREADY_O  <= 1'b0;
         S_AXI_BVALID_O  <= 1'b0;
         S_AXI_BRESP_O   <= `USC_RESP_OKAY;
         S_AXI_ARREADY_O <= 1'b0;
         S_AXI_RVALID_O  <= 1'b0;
         S_AXI_RRESP_O   <= `USC_RESP_OKAY;
         S_AXI_RDATA_O   <= 32'h0;
         aw_addr_reg     <= 8'h0;
         aw_got_reg      <= 1'b0;
         w_data_reg      <= 32'h0;
         w_strb_reg      <= 1'b0;
         w_got_reg       <= 1'b0;
      end else begin
         S_AXI_AWREADY_O <= ~aw_got_reg & ~(S_AXI_AWVALID_I & S_AXI_AWREADY_O) & ~wr_fire;
         S_AXI_WREADY_O  <= ~w_got_reg & ~(S_AXI_WVALID_I & S_AXI_WREADY_O) & ~wr_fire;
         if (S_AXI_AWVALID_I & S_AXI_AWREADY_O) begin
            aw_addr_reg <= S_AXI_AWADDR_I;
            aw_got_reg  <= 1'b1;
         end
         if (S_AXI_WVALID_I & S_AXI_WREADY_O) begin
            w_data_reg <= S_AXI_WDATA_I;
            w_strb_reg <= S_AXI_WSTRB_I[0];
            w_got_reg  <= 1'b1;
         end
         if (wr_fire) begin
            aw_got_reg     <= 1'b0;
            w_got_reg      <= 1'b0;
            S_AXI_BVALID_O <= 1'b1;
            S_AXI_BRESP_O  <= mapped(aw_addr_reg) ? `USC_RESP_OKAY : `USC_RESP_SLVERR;
         end else if (S_AXI_BREADY_I) begin
            S_AXI_BVALID_O <= 1'b0;
         end
         S_AXI_ARREADY_O <= ~S_AXI_RVALID_O & ~rd_fire;
         if (rd_fire) begin
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RDATA_O  <= {24'h0, rdata_next};
            S_AXI_RRESP_O  <= mapped(S_AXI_ARADDR_I) ? `USC_RESP_OKAY : `USC_RESP_SLVERR;
         end else if (S_AXI_RREADY_I) begin
            S_AXI_RVALID_O <= 1'b0;
         end
      end
   end

   always @* begin
      case (S_AXI_ARADDR_I)
         `USC_OFS_CTRL1:  rdata_next = {ctrl1_reg[7:1], 1'b0}; // ninth transmit bit is write-only
         `USC_OFS_CTRL2:  rdata_next = ctrl2_reg;
         `USC_OFS_SWCTRL: rdata_next = {7'h0, swmode_reg};
         `USC_OFS_DATA:   rdata_next = data_buf_reg;
         `USC_OFS_BAUD:   rdata_next = baud_reg;
         `USC_OFS_STATUS: rdata_next = status;
         default:         rdata_next = 8'h0;
      endcase
   end

   // ************
   // control and flag state
   // ************
   always @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         ctrl1_reg     <= `USC_CTRL_RST;
         ctrl2_reg     <= `USC_CTRL_RST;
         swmode_reg    <= 1'b0;
         data_buf_reg  <= 8'h0;
         baud_reg      <= 8'h0;
         ovfl_reg      <= 1'b0;
         rxav_reg      <= 1'b0;
         txmt_reg      <= 1'b1;
         txidl_reg     <= 1'b1;
         wake_reg      <= 1'b0;
         tx_pend_reg   <= 1'b0;
         stat_seen_reg <= 1'b0;
         rx_prev_reg   <= 1'b1;
      end else begin
         rx_prev_reg <= rx_pin;
         if (wr_fire & w_strb_reg) begin
            case (aw_addr_reg)
               `USC_OFS_CTRL1:  ctrl1_reg <= {w_data_reg[7:2], ctrl1_reg[`USC_C1_RX9],
                                              w_data_reg[`USC_C1_TX9]};
               `USC_OFS_CTRL2:  ctrl2_reg <= w_data_reg[7:0];
               `USC_OFS_SWCTRL: swmode_reg <= w_data_reg[0];
               `USC_OFS_BAUD:   baud_reg <= w_data_reg[7:0];
               `USC_OFS_STATUS: wake_reg <= wake_reg & ~w_data_reg[`USC_ST_WAKE];
               default:         stat_seen_reg <= stat_seen_reg;
            endcase
         end
         if (rd_fire & (S_AXI_ARADDR_I == `USC_OFS_STATUS)) begin
            stat_seen_reg <= 1'b1;
         end
         // writes are refused while the previous byte still waits
         if (wr_data & txmt_reg) begin
            data_buf_reg <= w_data_reg[7:0];
            tx_pend_reg  <= 1'b1;
            txmt_reg     <= 1'b0;
            txidl_reg    <= 1'b0;
         end
         if (rd_data & stat_seen_reg) begin
            rxav_reg      <= 1'b0;
            ovfl_reg      <= 1'b0;
            stat_seen_reg <= 1'b0;
         end
         if (tx_load) begin
            tx_pend_reg <= 1'b0;
            txmt_reg    <= 1'b1;
         end
         if (txmt_reg & ~tx_pend_reg & ~tx_busy & ~ctrl1_reg[`USC_C1_BREAK]) begin
            txidl_reg <= 1'b1;
         end
         // set beats the read-side clear
         if (rx_done_reg) begin
            if (ctrl2_reg[`USC_C2_ADDR_EN] & ~addr_bit) begin
               rxav_reg <= rxav_reg;
            end else if (rxav_reg & ~(rd_data & stat_seen_reg)) begin
               ovfl_reg <= 1'b1;
            end else begin
               data_buf_reg              <= rx_word[7:0];
               ctrl1_reg[`USC_C1_RX9]    <= rx_word[8];
               rxav_reg                  <= 1'b1;
            end
         end
         // wake watches the pin only while the peripheral clock is off
         if (PERIPH_CLK_OFF_I & ctrl2_reg[`USC_C2_WAKE_EN] & rx_prev_reg & ~rx_pin) begin
            wake_reg <= 1'b1;
         end
         if (~ctrl2_reg[`USC_C2_TX_EN]) begin
            tx_pend_reg <= 1'b0;
            txmt_reg    <= 1'b1;
         end
         if (~ctrl2_reg[`USC_C2_RX_EN]) begin
            rxav_reg <= 1'b0;
            ovfl_reg <= 1'b0;
         end
         if (~port_en) begin
            ctrl2_reg[`USC_C2_TX_EN:`USC_C2_RX_EN] <= 2'h0;
            ctrl1_reg[`USC_C1_BREAK]               <= 1'b0;
            rxav_reg                               <= 1'b0;
            ovfl_reg                               <= 1'b0;
            tx_pend_reg                            <= 1'b0;
            txmt_reg                               <= 1'b1;
            txidl_reg                              <= 1'b1;
         end
      end
   end

   // ************
   // transmitter
   // ************
   always @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         tx_state_reg <= ST_IDLE;
         tx_os_reg    <= 4'h0;
         tx_idx_reg   <= 4'h0;
         tsr_reg      <= 9'h0;
         tx_line_reg  <= 1'b1;
      end else if (~tx_en) begin
         tx_state_reg <= ST_IDLE;
         tx_line_reg  <= 1'b1;
      end else if (tx_load) begin
         tsr_reg      <= {ctrl1_reg[`USC_C1_TX9] & word9, data_buf_reg};
         tx_state_reg <= ST_START;
         tx_os_reg    <= 4'h0;
         tx_idx_reg   <= 4'h0;
         tx_line_reg  <= 1'b0;
      end else if ((tx_state_reg == ST_IDLE) & ctrl1_reg[`USC_C1_BREAK] & ~tx_pend_reg) begin
         tx_state_reg <= ST_BRK;
         tx_os_reg    <= 4'h0;
         tx_idx_reg   <= 4'h0;
         tx_line_reg  <= 1'b0;
      end else if (tick) begin
         tx_os_reg <= tx_os_reg + 4'h1;
         if (tx_os_reg == `USC_OVERSAMPLE) begin
            case (tx_state_reg)
               ST_START: begin
                  tx_state_reg <= ST_DATA;
                  tx_line_reg  <= tsr_reg[0];
               end
               ST_DATA: begin
                  tsr_reg    <= {1'b0, tsr_reg[8:1]};
                  tx_idx_reg <= tx_idx_reg + 4'h1;
                  if (tx_idx_reg == last_bit) begin
                     tx_state_reg <= ST_STOP;
                     tx_line_reg  <= 1'b1;
                  end else begin
                     tx_line_reg <= tsr_reg[1];
                  end
               end
               ST_STOP: begin
                  tx_state_reg <= ST_IDLE;
               end
               ST_BRK: begin
                  if (tx_idx_reg != `USC_BREAK_BITS) begin
                     tx_idx_reg <= tx_idx_reg + 4'h1;
                  end else if (~ctrl1_reg[`USC_C1_BREAK]) begin
                     tx_state_reg <= ST_IDLE;
                     tx_line_reg  <= 1'b1;
                  end
               end
               default: tx_state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // ************
   // receiver
   // ************
   always @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         rx_state_reg <= ST_IDLE;
         rx_os_reg    <= 4'h0;
         rx_idx_reg   <= 4'h0;
         rsr_reg      <= 9'h0;
         rx_done_reg  <= 1'b0;
      end else begin
         rx_done_reg <= 1'b0;
         if (~rx_en) begin
            rx_state_reg <= ST_IDLE;
         end else if (tick) begin
            rx_os_reg <= rx_os_reg + 4'h1;
            case (rx_state_reg)
               ST_IDLE: begin
                  if (~rx_line) begin
                     rx_state_reg <= ST_START;
                     rx_os_reg    <= 4'h0;
                  end
               end
               ST_START: begin
                  if (rx_os_reg == `USC_MID_SAMPLE) begin
                     rx_state_reg <= rx_line ? ST_IDLE : ST_DATA;
                     rx_os_reg    <= 4'h0;
                     rx_idx_reg   <= 4'h0;
                  end
               end
               ST_DATA: begin
                  if (rx_os_reg == `USC_OVERSAMPLE) begin
                     rsr_reg    <= {rx_line, rsr_reg[8:1]};
                     rx_idx_reg <= rx_idx_reg + 4'h1;
                     if (rx_idx_reg == last_bit) begin
                        rx_state_reg <= ST_STOP;
                     end
                  end
               end
               ST_STOP: begin
                  if (rx_os_reg == `USC_OVERSAMPLE) begin
                     rx_state_reg <= ST_IDLE;
                     rx_done_reg  <= 1'b1;
                  end
               end
               default: rx_state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // ************
   // pins and interrupt
   // ************
   always @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         TX_O      <= 1'b1;
         TX_OE_O   <= 1'b0;
         RXTX_O    <= 1'b1;
         RXTX_OE_O <= 1'b0;
         IRQ_O     <= 1'b0;
      end else begin
         TX_O      <= tx_line_reg;
         TX_OE_O   <= tx_en & ~swmode_reg;
         RXTX_O    <= tx_line_reg;
         RXTX_OE_O <= sw_tx;
         IRQ_O     <= (ctrl2_reg[`USC_C2_RX_IE] & (ovfl_reg | rxav_reg)) |
                      (ctrl2_reg[`USC_C2_TXIDL_IE] & txidl_reg) |
                      (ctrl2_reg[`USC_C2_TEMPTY_IE] & txmt_reg) |
                      wake_reg;
      end
   end
endmodule // usc_top
`default_nettype wire

/* tb/usc_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module usc_top_asserts (
   input wire logic        CORE_CLK_I,
   input wire logic        SYS_RST_I,
   input wire logic [7:0]  S_AXI_AWADDR_I,
   input wire logic        S_AXI_AWVALID_I,
   input wire logic        S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic        S_AXI_WVALID_I,
   input wire logic        S_AXI_WREADY_O,
   input wire logic        S_AXI_BVALID_O,
   input wire logic [7:0]  S_AXI_ARADDR_I,
   input wire logic        S_AXI_ARVALID_I,
   input wire logic        S_AXI_ARREADY_O,
   input wire logic [31:0] S_AXI_RDATA_O,
   input wire logic        S_AXI_RVALID_O,
   input wire logic        S_AXI_RREADY_I,
   input wire logic        RXTX_OE_O,
   input wire logic        TX_OE_O,
   input wire logic        IRQ_O
);
   logic [3:0] en_reg;
   logic [3:0] ie_reg;
   logic [7:0] ar_reg;
   wire        wr_hs = S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
   wire [7:0]  wd = S_AXI_WDATA_I[7:0];
   // shadow of port, tx, rx and single wire enables as software wrote them
   always_ff @(posedge CORE_CLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         en_reg <= 4'h0;
         ie_reg <= 4'h0;
         ar_reg <= 8'h00;
      end else begin
         if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
            ar_reg <= S_AXI_ARADDR_I;
         if (wr_hs && S_AXI_AWADDR_I == 8'h00)
            en_reg <= wd[7] ? {1'b1, en_reg[2:0]} : {3'h0, en_reg[0]};
         if (wr_hs && S_AXI_AWADDR_I == 8'h04) begin
            en_reg[2:1] <= wd[7:6];
            ie_reg <= wd[3:0];
         end
         if (wr_hs && S_AXI_AWADDR_I == 8'h08)
            en_reg[0] <= wd[0];
      end
   end
   wire tx_ok = en_reg[3] && en_reg[2] && !en_reg[0];
   wire sw_ok = en_reg[3] && en_reg[2] && !en_reg[1] && en_reg[0];
   default clocking cb @(posedge CORE_CLK_I); endclocking
   default disable iff (SYS_RST_I);
   sequence s_wr; wr_hs; endsequence
   sequence s_rd_end; S_AXI_RVALID_O && S_AXI_RREADY_I; endsequence
   // four cycles of slack cover the register write and the pin register
   property p_tx_pin; !tx_ok [*4] |-> !TX_OE_O; endproperty
   property p_rxtx_pin; !sw_ok [*4] |-> !RXTX_OE_O; endproperty
   property p_one_drv; !(TX_OE_O && RXTX_OE_O); endproperty
   property p_irq_quiet; ie_reg == 4'h0 [*4] |-> !IRQ_O; endproperty
   property p_wr_resp; s_wr |-> ##[1:2] S_AXI_BVALID_O; endproperty
   property p_wr_busy; s_wr |=> !S_AXI_AWREADY_O && !S_AXI_WREADY_O; endproperty
   property p_rd_resp; S_AXI_ARVALID_I && S_AXI_ARREADY_O |-> ##[1:2] S_AXI_RVALID_O; endproperty
   property p_rd_one; s_rd_end |=> !S_AXI_RVALID_O; endproperty
   property p_rd_data;
      S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h0 && (ar_reg != 8'h08 || S_AXI_RDATA_O[7:1] == 7'h0);
   endproperty
   a_tx_pin: assert property (p_tx_pin)
      else $error("tx pin driven while not enabled");
   a_rxtx_pin: assert property (p_rxtx_pin)
      else $error("shared pin driven while not a transmitter");
   a_one_drv: assert property (p_one_drv)
      else $error("both pins driven");
   a_irq_quiet: assert property (p_irq_quiet)
      else $error("irq with every source disabled");
   a_wr_resp: assert property (p_wr_resp) else $error("no write response");
   a_wr_busy: assert property (p_wr_busy) else $error("write ready during response");
   a_rd_resp: assert property (p_rd_resp) else $error("no read response");
   a_rd_one: assert property (p_rd_one) else $error("read response repeated");
   a_rd_data: assert property (p_rd_data)
      else $error("unimplemented read bits not zero");
endmodule // usc_top_asserts
bind usc_top usc_top_asserts usc_top_asserts_inst (.*);
`default_nettype wire

/* tb/usc_line_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module usc_line_peer (
   input  wire logic clk_i,
   input  wire logic line_i,
   output var  logic line_o
);
   int         bit_cyc = 32;
   int         rx_cnt = 0;
   logic [7:0] rx_word;
   initial line_o = 1'b1;
   task automatic send(input logic [7:0] w);
      begin
         @(posedge clk_i);
         line_o <= 1'b0;
         repeat (bit_cyc) @(posedge clk_i);
         for (int i = 0; i < 8; i++) begin
            line_o <= w[i];
            repeat (bit_cyc) @(posedge clk_i);
         end
         line_o <= 1'b1;
         repeat (bit_cyc) @(posedge clk_i);
      end
   endtask
   // samples mid-bit, returns at mid-stop to catch the next start
   always begin
      @(negedge line_i);
      repeat (bit_cyc / 2) @(posedge clk_i);
      for (int i = 0; i < 8; i++) begin
         repeat (bit_cyc) @(posedge clk_i);
         rx_word[i] = line_i;
      end
      repeat (bit_cyc) @(posedge clk_i);
      rx_cnt++;
   end
endmodule // usc_line_peer
`default_nettype wire

/* tb/usc_top_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module usc_top_bench;
   logic clk = 1'b0, rst = 1'b1, clk_off = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, got;
   logic [1:0] resp;
   logic [3:0] wstrb = 4'hf;
   int num_errors = 0, check_count = 0;
   wire awready, wready, bvalid, arready, rvalid, rxtx_o, rxtx_oe, tx_o, tx_oe, irq, peer_line;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   wire rxtx = rxtx_oe ? rxtx_o : peer_line;
   wire tx_line = tx_oe ? tx_o : 1'b1; // pull-up while floating
   always #2 clk = ~clk;
   usc_top usc_top_inst (.CORE_CLK_I(clk), .SYS_RST_I(rst), .PERIPH_CLK_OFF_I(clk_off),
      .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
      .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid),
      .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
      .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
      .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
      .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .RXTX_I(rxtx), .RXTX_O(rxtx_o),
      .RXTX_OE_O(rxtx_oe), .TX_O(tx_o), .TX_OE_O(tx_oe), .IRQ_O(irq));
   usc_line_peer usc_line_peer_inst (.clk_i(clk), .line_i(tx_line), .line_o(peer_line));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      resp = bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      got = rdata;
      resp = rresp;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
      rd(a);
      chk(what, exp, got);
      chk("read response", 32'h0, resp);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #100000;
      num_errors++;
      finish_test;
   end
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      rdc(8'h04, 32'h0, "control two reset");
      rdc(8'h14, 32'h0b, "status reset");
      wr(8'h08, 8'hff);
      rdc(8'h08, 32'h01, "single wire bits");
      wr(8'h08, 8'h00);
      wstrb <= 4'h0;
      wr(8'h10, 8'h5a);
      wstrb <= 4'hf;
      rdc(8'h10, 32'h0, "masked write");
      rd(8'h18);
      chk("unmapped response", 32'h2, resp);
      $display("registers done");
      wr(8'h00, 8'h80);
      for (int k = 0; k < 2; k++) begin
         wr(8'h10, k ? 8'h00 : 8'h01);
         wr(8'h04, k ? 8'h80 : 8'ha0);
         usc_line_peer_inst.bit_cyc = k ? 64 : 32;
         wr(8'h0c, 8'ha5 ^ k[7:0]);
         wait (usc_line_peer_inst.rx_cnt == k + 1);
         chk("sent byte", 8'ha5 ^ k[7:0], usc_line_peer_inst.rx_word);
      end
      wr(8'h0c, 8'h00);
      repeat (100) @(posedge clk);
      wr(8'h04, 8'h00);
      repeat (3) @(posedge clk);
      chk("tx pin enable", 32'h0, tx_oe);
      rdc(8'h14, 32'h0b, "status after abort");
      $display("transmit done");
      wr(8'h04, 8'h44);
      usc_line_peer_inst.send(8'h3c);
      chk("receive irq", 32'h1, irq);
      rdc(8'h14, 32'h0f, "status received");
      rdc(8'h0c, 32'h3c, "received byte");
      repeat (2) @(posedge clk);
      chk("receive irq cleared", 32'h0, irq);
      wr(8'h04, 8'h50);
      usc_line_peer_inst.send(8'h12);
      rdc(8'h14, 32'h0b, "status data word");
      usc_line_peer_inst.send(8'h92);
      rdc(8'h14, 32'h0f, "status address word");
      rdc(8'h0c, 32'h92, "address byte");
      $display("receive done");
      wr(8'h04, 8'h08);
      clk_off <= 1'b1;
      usc_line_peer_inst.send(8'h00);
      chk("wake irq", 32'h1, irq);
      rdc(8'h14, 32'h2b, "status wake");
      wr(8'h14, 8'h20);
      clk_off <= 1'b0;
      usc_line_peer_inst.send(8'h00);
      rdc(8'h14, 32'h0b, "status clock running");
      wr(8'h04, 8'hc0);
      wr(8'h00, 8'h00);
      rdc(8'h04, 32'h0, "enables after port off");
      $display("wake done");
      wr(8'h00, 8'h80);
      wr(8'h08, 8'h01);
      for (int k = 0; k < 2; k++) begin
         wr(8'h04, k ? 8'hc0 : 8'h80);
         repeat (2) @(posedge clk);
         chk("single wire enables", {30'h0, ~k[0], 1'b0}, {30'h0, rxtx_oe, tx_oe});
      end
      $display("single wire done");
      finish_test;
   end
endmodule // usc_top_bench
`default_nettype wire
